// file: pkg/cvc_pkg.sv
// Constants, types and register map of the card-side answer-to-reset block
package cvc_pkg;
   // APB byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CLASS = 8'h04;
   localparam logic [7:0] A_SPEED = 8'h08;
   localparam logic [7:0] A_HIST = 8'h0C;
   localparam logic [7:0] A_STAT = 8'h10;
   localparam logic [7:0] A_CLR = 8'h14;
   localparam logic [7:0] A_IEN = 8'h18;
   // Reset values
   localparam logic [4:0] CLASS_RST = 5'h01;
   localparam logic [1:0] CSTOP_RST = 2'h0;
   localparam logic [7:0] SPEED_DEF = 8'h11;
   // Speed factor codes, FI in high nibble, DI in low nibble
   localparam logic [7:0] F512_D8 = 8'h94;
   localparam logic [7:0] F512_D16 = 8'h98;
   localparam logic [3:0] FI_512 = 4'h9;
   localparam logic [3:0] DI_64 = 4'h7;
   // Answer-to-reset characters
   localparam logic [7:0] TS_DIRECT = 8'h3B;
   localparam logic [3:0] T0_Y1 = 4'h9;
   localparam logic [3:0] HIST_LEN = 4'h7;
   localparam logic [7:0] TD1_T0 = 8'h80;
   localparam logic [7:0] TD2_T15 = 8'h1F;
   localparam logic [3:0] T_GLOBAL = 4'hF;
   localparam logic [7:0] CAT_TLV = 8'h80;
   localparam logic [7:0] TAG_SVC = 8'h31;
   localparam logic [7:0] TAG_CAP = 8'h73;
   localparam logic [3:0] ATR_LAST = 4'hD;
   // Character framing: start, 8 data, parity, then two guard etu
   localparam logic [3:0] BIT_PAR = 4'h9;
   localparam logic [3:0] BIT_LAST = 4'hB;
   localparam logic [8:0] ETU_DEF = 9'h174;
   // Status bit positions
   localparam int ST_DONE = 0;
   localparam int ST_RST = 1;
   localparam int ST_CFG = 2;
   localparam int N_EVT = 3;

   typedef struct packed {
      logic [1:0] clkstop;
      logic [4:0] classes;
      logic [7:0] speed;
      logic [7:0] svc;
      logic [23:0] caps;
   } cvc_cfg_t;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_WAIT = 4'b0010,
      S_SEND = 4'b0100,
      S_DONE = 4'b1000
   } cvc_state_t;
endpackage

// file: hdl/cvc_card_atr.sv
// Card-side answer-to-reset sender with voltage class and speed checks
`timescale 1ns/1ps
`default_nettype none

module cvc_card_atr
   import cvc_pkg::*;
#(
   parameter int ATR_DLY_CLK = 400
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic card_clk,
   input wire logic card_rst,
   input wire logic io_in,
   output logic io_out,
   output logic io_oe_n,
   output logic irq
);

   if (ATR_DLY_CLK < 1 || ATR_DLY_CLK > 65535) begin : g_chk
      $error("ATR_DLY_CLK out of range");
   end

   localparam logic [15:0] DLY_M1 = 16'(ATR_DLY_CLK - 1);

   function automatic logic cls_ok(input logic [4:0] c);
      logic [4:0] l;
      l = c & (~c + 5'h01);
      cls_ok = (c != 5'h00) && (((c + l) & c) == 5'h00);
   endfunction

   function automatic logic speed_ok(input logic [7:0] s);
      speed_ok = (s == SPEED_DEF) || (s == F512_D8) || (s == F512_D16)
         || (s == {FI_512, DI_64});
   endfunction

   function automatic logic [7:0] tck_of(input cvc_cfg_t c);
      tck_of = {T0_Y1, HIST_LEN} ^ c.speed ^ TD1_T0 ^ TD2_T15
         ^ {c.clkstop, 1'b0, c.classes} ^ CAT_TLV ^ TAG_SVC ^ c.svc
         ^ TAG_CAP ^ c.caps[7:0] ^ c.caps[15:8] ^ c.caps[23:16];
   endfunction

   function automatic logic [7:0] atr_byte(input logic [3:0] i, input cvc_cfg_t c);
      case (i)
         4'h0: atr_byte = TS_DIRECT;
         4'h1: atr_byte = {T0_Y1, HIST_LEN};
         4'h2: atr_byte = c.speed;
         4'h3: atr_byte = TD1_T0;
         4'h4: atr_byte = TD2_T15;
         4'h5: atr_byte = {c.clkstop, 1'b0, c.classes};
         4'h6: atr_byte = CAT_TLV;
         4'h7: atr_byte = TAG_SVC;
         4'h8: atr_byte = c.svc;
         4'h9: atr_byte = TAG_CAP;
         4'hA: atr_byte = c.caps[7:0];
         4'hB: atr_byte = c.caps[15:8];
         4'hC: atr_byte = c.caps[23:16];
         default: atr_byte = tck_of(c);
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic clk_s1_r, clk_s2_r, clk_s3_r;
   logic rst_s1_r, rst_s2_r, rst_s3_r;
   logic io_s1_r, io_s2_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {clk_s1_r, clk_s2_r, clk_s3_r} <= 3'h0;
         {rst_s1_r, rst_s2_r, rst_s3_r} <= 3'h0;
         {io_s1_r, io_s2_r} <= 2'h3;
      end else begin
         {clk_s1_r, clk_s2_r, clk_s3_r} <= {card_clk, clk_s1_r, clk_s2_r};
         {rst_s1_r, rst_s2_r, rst_s3_r} <= {card_rst, rst_s1_r, rst_s2_r};
         {io_s1_r, io_s2_r} <= {io_in, io_s1_r};
      end
   end

   wire logic clk_rise = clk_s2_r & ~clk_s3_r;
   wire logic rst_fall = rst_s3_r & ~rst_s2_r;

   ////////////////////////////////////////////////////////////////////////
   // APB slave, one wait state
   logic en_r;
   cvc_cfg_t cfg_r;
   logic [N_EVT-1:0] stat_r, ien_r;
   logic pready_r, pslverr_r, irq_r;
   logic [31:0] prdata_r;
   cvc_state_t st_r;

   wire logic acc = psel & penable;
   wire logic wr = acc & pready_r & pwrite;
   wire logic hit = (paddr == A_CTRL) || (paddr == A_CLASS) || (paddr == A_SPEED)
      || (paddr == A_HIST) || (paddr == A_STAT) || (paddr == A_CLR) || (paddr == A_IEN);
   wire logic wr_class = wr && (paddr == A_CLASS);
   wire logic wr_speed = wr && (paddr == A_SPEED);
   wire logic class_good = cls_ok(pwdata[4:0]);
   wire logic speed_good = speed_ok(pwdata[7:0]);
   wire logic bad_wr = (wr_class & ~class_good) | (wr_speed & ~speed_good);
   wire logic [N_EVT-1:0] clr = (wr && (paddr == A_CLR)) ? pwdata[N_EVT-1:0] : '0;

   logic [31:0] rd_mux;
   always_comb begin
      case (paddr)
         A_CTRL: rd_mux = {31'h0, en_r};
         A_CLASS: rd_mux = {24'h0, cfg_r.clkstop, 1'b0, cfg_r.classes};
         A_SPEED: rd_mux = {24'h0, cfg_r.speed};
         A_HIST: rd_mux = {cfg_r.caps, cfg_r.svc};
         A_STAT: rd_mux = {19'h0, io_s2_r, st_r, 5'h0, stat_r};
         A_IEN: rd_mux = {29'h0, ien_r};
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         pready_r <= acc & ~pready_r;
         pslverr_r <= acc & ~pready_r & ~hit;
         prdata_r <= (acc & ~pready_r & ~pwrite) ? rd_mux : 32'h0;
      end
   end

   // Illegal class or speed sets are refused whole, old value kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= 1'b0;
         cfg_r <= '{CSTOP_RST, CLASS_RST, SPEED_DEF, 8'h00, 24'h0};
         ien_r <= '0;
      end else begin
         if (wr && (paddr == A_CTRL)) en_r <= pwdata[0];
         if (wr_class && class_good) begin
            cfg_r.classes <= pwdata[4:0];
            cfg_r.clkstop <= pwdata[7:6];
         end
         if (wr_speed && speed_good) cfg_r.speed <= pwdata[7:0];
         if (wr && (paddr == A_HIST)) {cfg_r.caps, cfg_r.svc} <= pwdata;
         if (wr && (paddr == A_IEN)) ien_r <= pwdata[N_EVT-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Answer sequencer, counted in sampled card clock edges
   logic [15:0] dly_r;
   logic [8:0] etu_r;
   logic [3:0] bit_r, idx_r;
   wire logic etu_end = clk_rise && (etu_r == ETU_DEF - 9'h001);
   wire logic atr_end = (st_r == S_SEND) && etu_end && (bit_r == BIT_LAST)
      && (idx_r == ATR_LAST);
   wire logic [7:0] cur_byte = atr_byte(idx_r, cfg_r);
   logic frame_bit;
   always_comb begin
      if (bit_r == 4'h0) frame_bit = 1'b0;
      else if (bit_r < BIT_PAR) frame_bit = cur_byte[3'(bit_r - 4'h1)];
      else if (bit_r == BIT_PAR) frame_bit = ^cur_byte;
      else frame_bit = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= S_IDLE;
         dly_r <= 16'h0;
         etu_r <= 9'h0;
         bit_r <= 4'h0;
         idx_r <= 4'h0;
      end else if (!rst_s2_r) begin
         st_r <= S_IDLE;
      end else begin
         case (st_r)
            S_IDLE: begin
               if (en_r && rst_s2_r && !rst_s3_r) begin
                  st_r <= S_WAIT;
                  dly_r <= 16'h0;
               end
            end
            S_WAIT: begin
               if (clk_rise) begin
                  dly_r <= dly_r + 16'h0001;
                  if (dly_r == DLY_M1) begin
                     st_r <= S_SEND;
                     {etu_r, bit_r, idx_r} <= '0;
                  end
               end
            end
            S_SEND: begin
               // Default etu only: no parameter selection exchange here
               if (clk_rise) etu_r <= etu_end ? 9'h0 : etu_r + 9'h001;
               if (etu_end) begin
                  bit_r <= (bit_r == BIT_LAST) ? 4'h0 : bit_r + 4'h1;
                  if (bit_r == BIT_LAST) idx_r <= idx_r + 4'h1;
                  if (atr_end) st_r <= S_DONE;
               end
            end
            S_DONE: st_r <= S_DONE;
            default: st_r <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drive, interrupt status
   logic io_oe_n_r;
   wire logic [N_EVT-1:0] evt = {bad_wr, rst_fall && (st_r != S_IDLE), atr_end};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_oe_n_r <= 1'b1;
         stat_r <= '0;
         irq_r <= 1'b0;
      end else begin
         // Open drain: only low is driven, high comes from the pull-up
         io_oe_n_r <= !((st_r == S_SEND) && rst_s2_r && !frame_bit);
         stat_r <= (stat_r & ~clr) | evt;
         irq_r <= |(stat_r & ien_r);
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign io_out = 1'b0;
   assign io_oe_n = io_oe_n_r;
   assign irq = irq_r;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Table bytes named so that fields can be picked out of them
   wire logic [7:0] td1_byte = atr_byte(4'h3, cfg_r);
   wire logic [7:0] td2_byte = atr_byte(4'h4, cfg_r);
   wire logic [7:0] ta3_byte = atr_byte(4'h5, cfg_r);

   a_class_adjacent: assert property (cls_ok(cfg_r.classes))
      else $error("declared class set not adjacent");
   a_speed_pair: assert property (speed_ok(cfg_r.speed))
      else $error("unsupported speed pair stored");
   a_di64_fi: assert property (cfg_r.speed[3:0] == DI_64
      |-> cfg_r.speed[7:4] == FI_512)
      else $error("DI 64 without FI 512");
   a_ta3_class: assert property (ta3_byte[4:0] == cfg_r.classes && !ta3_byte[5])
      else $error("class byte differs from config");
   a_t15_global: assert property (td2_byte[3:0] == T_GLOBAL && td1_byte[7])
      else $error("T=15 indication missing");
   a_hist_order: assert property (atr_byte(4'h6, cfg_r) == CAT_TLV
      && atr_byte(4'h7, cfg_r) == TAG_SVC && atr_byte(4'h9, cfg_r) == TAG_CAP)
      else $error("historical header wrong");
   a_ta1_speed: assert property (wr_speed && speed_good |=>
      atr_byte(4'h2, cfg_r) == $past(pwdata[7:0]))
      else $error("TA1 not updated");
   a_etu_default: assert property ((st_r == S_SEND) && clk_rise && etu_r == 9'h0
      && rst_s2_r |-> ##1 (etu_r == 9'h1) && (bit_r == $past(bit_r)))
      else $error("etu counter slipped");
   a_bad_refused: assert property (wr_class && !class_good |=>
      cfg_r.classes == $past(cfg_r.classes) && stat_r[ST_CFG])
      else $error("illegal class write not refused");
   a_io_released: assert property (st_r != S_SEND |=> io_oe_n)
      else $error("line driven outside answer");
   a_abort_release: assert property (!rst_s2_r |=> io_oe_n)
      else $error("line driven while card reset low");
   a_start_low: assert property ($rose(st_r == S_SEND) && rst_s2_r |=> !io_oe_n)
      else $error("start bit missing");
   // Set must beat a clear written in the same cycle
   a_set_wins: assert property (|evt |=> (stat_r & $past(evt)) == $past(evt))
      else $error("status event lost");
   a_irq_level: assert property (irq == |($past(stat_r) & $past(ien_r)))
      else $error("interrupt level wrong");

   c_atr_done: cover property ($rose(st_r == S_DONE));
   c_irq_seen: cover property ($rose(irq));
   c_bad_write: cover property (bad_wr);
   c_reset_abort: cover property ((st_r == S_SEND) && rst_fall);
   c_answer_start: cover property ($rose(st_r == S_SEND));
endmodule

`default_nettype wire

// file: testbench/cvc_term_model.sv
// Behavioural terminal: gated card clock, card reset and pulled-up I/O receiver
`timescale 1ns/1ps
`default_nettype none

module cvc_term_model
   import cvc_pkg::*;
#(
   parameter int ANS_TO = 2000,
   parameter logic [4:0] TERM_CLS = 5'h07
) (
   input wire logic io_oe_n,
   input wire logic io_out,
   output logic card_clk,
   output logic card_rst,
   output logic io_level
);
   logic clk_on;
   logic [4:0] cur_cls;
   int bad_cnt;

   // Pull-up: a released line reads high, never the last driven level
   assign io_level = io_oe_n ? 1'b1 : io_out;

   initial begin
      card_clk = 1'b0;
      card_rst = 1'b0;
      clk_on = 1'b0;
      cur_cls = 5'h00;
      bad_cnt = 0;
   end

   // Clock stands still while the card is inactive
   always begin
      if (clk_on) #200 card_clk = ~card_clk;
      else @(clk_on);
   end

   // Lowest supply first: class C is the highest supported bit
   task automatic power_up();
      int k;
      cur_cls = 5'h00;
      bad_cnt = 0;
      for (k = 0; k < 5; k++) begin
         if (TERM_CLS[k]) cur_cls = 5'h01 << k;
      end
   endtask

   // No answer, or a third corrupted one: one class higher only
   task automatic step_up();
      if ((TERM_CLS & (cur_cls >> 1)) != 5'h00) cur_cls = cur_cls >> 1;
      bad_cnt = 0;
   endtask

   // Corrupted answer: same class again, three tries before moving
   task automatic note_corrupt();
      bad_cnt++;
      if (bad_cnt == 3) step_up();
   endtask

   // Class in use not declared: take the lowest declared one
   task automatic follow_card(input logic [4:0] decl);
      int k;
      if ((decl & cur_cls) == 5'h00) begin
         for (k = 0; k < 5; k++) begin
            if (decl[k] && TERM_CLS[k]) cur_cls = 5'h01 << k;
         end
      end
   endtask

   // Supply switching itself is not modelled; the class is bookkeeping
   task automatic activate();
      clk_on = 1'b1;
      repeat (8) @(posedge card_clk);
      card_rst = 1'b1;
   endtask

   task automatic deactivate();
      card_rst = 1'b0;
      repeat (2) @(posedge card_clk);
      clk_on = 1'b0;
   endtask

   // Every character is taken whole; its meaning is left to the caller
   task automatic recv_byte(output logic [7:0] b, output logic ok);
      logic [9:0] sh;
      int n;
      sh = '1;
      for (n = 0; n < ANS_TO && io_level !== 1'b0; n++) @(posedge card_clk);
      if (io_level !== 1'b0) begin
         b = 8'h00;
         ok = 1'b0;
         return;
      end
      // Default etu only: no speed selection was made
      repeat (ETU_DEF / 2) @(posedge card_clk);
      for (n = 0; n < 10; n++) begin
         sh[n] = io_level;
         repeat (ETU_DEF) @(posedge card_clk);
      end
      b = sh[8:1];
      ok = (sh[0] === 1'b0) && (^sh[9:1] === 1'b0);
   endtask
endmodule
`default_nettype wire

// file: testbench/card_voltage_class_atr_check_tb.sv
// Self-checking bench: register checks, refusals, interrupt and answer start
`timescale 1ns/1ps
`default_nettype none

module card_voltage_class_atr_check_tb
   import cvc_pkg::*;
;
   localparam logic [7:0] CLS_TAB [8] = '{8'h03, 8'h06, 8'h05, 8'h00, 8'h0C, 8'h09, 8'h18, 8'h07};
   // Bit i set: entry i is a non-empty set of adjacent classes
   localparam logic [7:0] CLS_GOOD = 8'hD3;
   localparam logic [7:0] SPD_TAB [6] = '{F512_D8, F512_D16, 8'h97, 8'h17, 8'h95, SPEED_DEF};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic card_clk, card_rst, io_level, io_out, io_oe_n;
   int error_cnt = 0;
   int check_count = 0;

   cvc_card_atr #(.ATR_DLY_CLK(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .card_clk(card_clk), .card_rst(card_rst),
      .io_in(io_level), .io_out(io_out), .io_oe_n(io_oe_n), .irq(irq));
   cvc_term_model #(.ANS_TO(1000)) term_u (.io_oe_n(io_oe_n), .io_out(io_out), .card_clk(card_clk),
      .card_rst(card_rst), .io_level(io_level));

   initial pclk = 1'b0;
   always #25 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////////

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
         input string what);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q & m, exp, what);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic final_report();
      $display("Checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // A missed answer and two characters take about 76000 cycles
   initial begin
      repeat (95000) @(posedge pclk);
      error_cnt++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      final_report();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] q;
      logic e;
      logic [7:0] b;
      logic ok;
      logic [4:0] exp_c;
      logic [7:0] exp_s;
      int i;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(A_CTRL, 32'h1, 32'h0, "ctrl reset");
      rd_chk(A_CLASS, 32'hFF, {24'h0, 3'h0, CLASS_RST}, "class reset");
      rd_chk(A_SPEED, 32'hFF, {24'h0, SPEED_DEF}, "speed reset");
      apb(1'b0, 8'h1C, 32'h0, q, e);
      chk(q, 32'h0, "unmapped data");
      chk({31'h0, e}, 32'h1, "unmapped error");
      rd_chk(A_STAT, 32'h1F00, 32'h1100, "idle state and line");
      wr(A_HIST, 32'hA5C30F81);
      rd_chk(A_HIST, 32'hFFFFFFFF, 32'hA5C30F81, "historical data");
      $display("Test reset done");
      exp_c = CLASS_RST;
      for (i = 0; i < 8; i++) begin
         wr(A_CLR, 32'h7);
         wr(A_CLASS, {24'h0, CLS_TAB[i]});
         if (CLS_GOOD[i]) exp_c = CLS_TAB[i][4:0];
         rd_chk(A_CLASS, 32'h1F, {27'h0, exp_c}, "class");
         rd_chk(A_STAT, 32'h4, {29'h0, !CLS_GOOD[i], 2'h0}, "class err");
      end
      wr(A_CLASS, 32'hC6);
      rd_chk(A_CLASS, 32'hFF, 32'hC6, "clock stop");
      $display("Test class done");
      exp_s = SPEED_DEF;
      for (i = 0; i < 6; i++) begin
         wr(A_CLR, 32'h7);
         wr(A_SPEED, {24'h0, SPD_TAB[i]});
         ok = SPD_TAB[i] inside {SPEED_DEF, F512_D8, F512_D16, {FI_512, DI_64}};
         if (ok) exp_s = SPD_TAB[i];
         rd_chk(A_SPEED, 32'hFF, {24'h0, exp_s}, "speed");
         rd_chk(A_STAT, 32'h4, {29'h0, !ok, 2'h0}, "speed err");
      end
      $display("Test speed done");
      wr(A_IEN, 32'h4);
      rd_chk(A_IEN, 32'h7, 32'h4, "irq enable");
      wr(A_SPEED, 32'h17);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h1, "irq raised");
      wr(A_CLR, 32'h4);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      wr(A_IEN, 32'h0);
      wr(A_SPEED, 32'h17);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr(A_CLR, 32'h7);
      $display("Test interrupt done");
      term_u.power_up();
      chk({27'h0, term_u.cur_cls}, 32'h4, "first class");
      term_u.activate();
      term_u.recv_byte(b, ok);
      chk({31'h0, ok}, 32'h0, "no answer while disabled");
      term_u.deactivate();
      term_u.step_up();
      chk({27'h0, term_u.cur_cls}, 32'h2, "next class");
      term_u.note_corrupt();
      term_u.note_corrupt();
      chk({27'h0, term_u.cur_cls}, 32'h2, "same class retry");
      term_u.note_corrupt();
      chk({27'h0, term_u.cur_cls}, 32'h1, "step after three");
      term_u.follow_card(5'h06);
      chk({27'h0, term_u.cur_cls}, 32'h4, "declared class");
      $display("Test class walk done");
      wr(A_CTRL, 32'h1);
      rd_chk(A_CTRL, 32'h1, 32'h1, "enable set");
      term_u.activate();
      term_u.recv_byte(b, ok);
      chk({24'h0, b}, {24'h0, TS_DIRECT}, "first char");
      chk({31'h0, ok}, 32'h1, "first frame");
      term_u.recv_byte(b, ok);
      chk({24'h0, b}, {24'h0, T0_Y1, HIST_LEN}, "format char");
      chk({31'h0, ok}, 32'h1, "format frame");
      term_u.deactivate();
      repeat (8) @(posedge pclk);
      chk({31'h0, io_oe_n}, 32'h1, "line released");
      rd_chk(A_STAT, 32'h3, 32'h2, "abort flag");
      rd_chk(A_STAT, 32'h0F00, 32'h0100, "idle after abort");
      $display("Test answer done");
      final_report();
   end
endmodule
`default_nettype wire
